// ===== hdl/imste_cfg.svh
// constants for the two-wire master start and transmit engine
`ifndef IMSTE_CFG_SVH
`define IMSTE_CFG_SVH
// ==========================================================
// timing
`define IMSTE_CLK_NS 20
`define IMSTE_INSTR_NS 80
`define IMSTE_INSTR_CLKS (`IMSTE_INSTR_NS / `IMSTE_CLK_NS)
`define IMSTE_HALF_CLKS (`IMSTE_INSTR_CLKS / 2)
`define IMSTE_LATE_INSTR 2
`define IMSTE_LATE_CLKS (`IMSTE_LATE_INSTR * `IMSTE_INSTR_CLKS)
`define IMSTE_PERIODS_PER_SCL 2
// ==========================================================
// field positions and reset values
`define IMSTE_CTRL2_START_BIT 0
`define IMSTE_CTRL2_RSTART_BIT 1
`define IMSTE_CTRL2_REQ_BITS 5
`define IMSTE_STAT_BF_BIT 0
`define IMSTE_STAT_SDET_BIT 3
`define IMSTE_CTRL2_ACK_BIT 6
`define IMSTE_RELOAD_W 7
`define IMSTE_LAST_DATA_BIT 4'h7
`define IMSTE_ACK_BIT_NUM 4'h8
`define IMSTE_BRG_RST 7'h00
`define IMSTE_BYTE_RST 8'h00
`endif

// ===== hdl/imste_pkg.sv
// types for the two-wire master start and transmit engine
package imste_pkg;
  typedef enum logic [3:0] {
    IDLE, S_WAIT, S_HOLD, RS_SCLLO, RS_SDAREL, RS_SCLREL, RS_HIGH, RS_SDALO,
    TX_LOW, TX_REL, TX_HIGH
  } imste_state_type;
  typedef struct packed {
    imste_state_type st;
    logic [6:0] bit_rate_counter;
    logic [3:0] div;
    logic [3:0] age;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] txbuf;
    logic scl_lo;
    logic sda_lo;
    logic sreq;
    logic rsreq;
    logic sdet;
    logic bf;
    logic ack;
    logic write_collision_flag;
    logic bcl;
    logic pif;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
  } imste_regs_type;
endpackage

// ===== hdl/imste_engine.sv
// master start, repeated start and byte transmit engine of a two-wire port
`timescale 1ns/1ps
`default_nettype none
`include "imste_cfg.svh"
// Operation
// - each generated clock period spans two counter rollovers, set by reload value.
// - counter halts while released clock line is not yet sampled high.
// - clock sampled high reloads counter from 7-bit reload field and restarts.
// - start request with both lines high reloads counter and starts counting.
// - both lines high at expiry: pull data low, set start-detected bit.
// - one more period, then clear start request, stop counter, hold data low.
// - both lines low at start, or clock low first: collision, abort, idle.
// - buffer write during start sets write collision, buffer unchanged.
// - request bit writes ignored until start or repeated start completes.
// - repeated start request accepted only while idle.
// - repeated start: clock low, release data one period, then release clock.
// - both high one period, data low one period, clear request, keep data low.
// - start-detected on start seen; interrupt flag only after final period.
// - repeated start collision: data low at clock rise, or clock low early.
// - buffer write during repeated start sets write collision, buffer unchanged.
// - buffer write sets buffer-full and starts counter; cleared after 8 bits.
// - bits msb first, changed in the same cycle as the falling edge; low one period, high one period.
// - data line released on eighth falling edge for slave acknowledge.
// - ninth falling edge samples data into acknowledge status bit.
// - after ninth clock: interrupt flag, counter reloaded and left to run down to zero, clock low, data released.
// - write while shifting sets write collision; within 2 instruction cycles (8 clocks) buffer still updates.
// - write collision cleared only by software.
// - counter reloads from low 7 bits, counts twice per instruction cycle, stops at zero.
module imste_engine (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // bus lines
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // software controls
  input wire logic [6:0] reload_in,
  input wire logic ctrl2_wr_in,
  input wire logic [4:0] ctrl2_data_in,
  input wire logic tx_wr_in,
  input wire logic [7:0] tx_data_in,
  input wire logic write_collision_flag_clr_in,
  input wire logic bcl_clr_in,
  input wire logic pif_clr_in,
  input wire logic sdet_clr_in,
  // software status
  output logic start_request_out,
  output logic repeated_start_request_out,
  output logic start_det_out,
  output logic buffer_full_flag_out,
  output logic ack_status_bit_out,
  output logic write_collision_flag_out,
  output logic bus_collision_flag_out,
  output logic port_interrupt_flag_out,
  output logic [7:0] transmit_buffer_out,
  output logic busy_out
);

  // ==========================================================
  // state
  imste_pkg::imste_regs_type r;
  imste_pkg::imste_regs_type n;
  logic tick;
  logic expire;
  logic scl_hi;
  logic sda_hi;
  logic start_busy;
  logic tx_busy;
  logic busy_nxt;
  logic busy_r;

  // abort any sequence: both lines released, requests dropped
  function automatic imste_pkg::imste_regs_type f_abort(input imste_pkg::imste_regs_type s);
    imste_pkg::imste_regs_type t;
    t = s;
    t.bcl = 1'b1;
    t.st = imste_pkg::IDLE;
    t.scl_lo = 1'b0;
    t.sda_lo = 1'b0;
    t.sreq = 1'b0;
    t.rsreq = 1'b0;
    t.bf = 1'b0;
    return t;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    n = r;
    scl_hi = r.scl_s;
    sda_hi = r.sda_s;
    // half instruction cycle tick: two counter steps per instruction cycle
    tick = (r.div == 4'(`IMSTE_HALF_CLKS - 1));
    expire = (r.bit_rate_counter == 7'h00);
    start_busy = (r.st != imste_pkg::IDLE) && (r.st != imste_pkg::TX_LOW) &&
                 (r.st != imste_pkg::TX_REL) && (r.st != imste_pkg::TX_HIGH);
    tx_busy = (r.st == imste_pkg::TX_LOW) || (r.st == imste_pkg::TX_REL) ||
              (r.st == imste_pkg::TX_HIGH);
    n.div = tick ? 4'h0 : r.div + 4'h1;
    n.scl_m = scl_in;
    n.scl_s = r.scl_m;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    // counter holds at zero until reloaded
    if (tick && r.bit_rate_counter != 7'h00)
    begin
      n.bit_rate_counter = r.bit_rate_counter - 7'h01;
    end
    if (r.age != 4'hF)
    begin
      n.age = r.age + 4'h1;
    end
    // clears first, so a same-cycle set below wins
    if (write_collision_flag_clr_in)
    begin
      n.write_collision_flag = 1'b0;
    end
    if (bcl_clr_in)
    begin
      n.bcl = 1'b0;
    end
    if (pif_clr_in)
    begin
      n.pif = 1'b0;
    end
    if (sdet_clr_in)
    begin
      n.sdet = 1'b0;
    end
    // request bits are locked while a start is in flight
    if (ctrl2_wr_in && !start_busy)
    begin
      n.sreq = ctrl2_data_in[`IMSTE_CTRL2_START_BIT];
      if (r.st == imste_pkg::IDLE)
      begin
        n.rsreq = ctrl2_data_in[`IMSTE_CTRL2_RSTART_BIT];
      end
    end
    if (tx_wr_in && start_busy)
    begin
      n.write_collision_flag = 1'b1;
    end
    if (tx_wr_in && tx_busy)
    begin
      n.write_collision_flag = 1'b1;
      // a quick rewrite still lands; the byte on the wire may be garbled
      if (r.age < 4'(`IMSTE_LATE_CLKS))
      begin
        n.txbuf = tx_data_in;
        n.shift = tx_data_in;
      end
    end
    case (r.st)
      imste_pkg::IDLE:
      begin
        if (r.sreq && !scl_hi && !sda_hi)
        begin
          n = f_abort(n);
        end
        else if (r.sreq && scl_hi && sda_hi)
        begin
          n.bit_rate_counter = reload_in;
          n.st = imste_pkg::S_WAIT;
        end
        else if (r.rsreq)
        begin
          n.scl_lo = 1'b1;
          n.st = imste_pkg::RS_SCLLO;
        end
        else if (tx_wr_in && !r.sreq)
        begin
          n.txbuf = tx_data_in;
          n.shift = tx_data_in;
          n.bf = 1'b1;
          n.bitn = 4'h0;
          n.age = 4'h0;
          n.bit_rate_counter = reload_in;
          n.scl_lo = 1'b1;
          n.sda_lo = ~tx_data_in[7];
          n.st = imste_pkg::TX_LOW;
        end
      end
      imste_pkg::S_WAIT:
      begin
        // clock dropping before our data edge means another master
        if (!scl_hi)
        begin
          n = f_abort(n);
        end
        else if (expire && sda_hi)
        begin
          n.sda_lo = 1'b1;
          n.sdet = 1'b1;
          n.bit_rate_counter = reload_in;
          n.st = imste_pkg::S_HOLD;
        end
        else if (expire)
        begin
          n = f_abort(n);
        end
      end
      imste_pkg::S_HOLD:
      begin
        if (expire)
        begin
          n.sreq = 1'b0;
          n.pif = 1'b1;
          n.st = imste_pkg::IDLE;
        end
      end
      imste_pkg::RS_SCLLO:
      begin
        if (!scl_hi)
        begin
          n.bit_rate_counter = reload_in;
          n.sda_lo = 1'b0;
          n.st = imste_pkg::RS_SDAREL;
        end
      end
      imste_pkg::RS_SDAREL:
      begin
        if (expire && sda_hi)
        begin
          n.scl_lo = 1'b0;
          n.st = imste_pkg::RS_SCLREL;
        end
        else if (expire)
        begin
          n = f_abort(n);
        end
      end
      imste_pkg::RS_SCLREL:
      begin
        // counter frozen until the released clock really rises
        if (scl_hi && !sda_hi)
        begin
          n = f_abort(n);
        end
        else if (scl_hi)
        begin
          n.bit_rate_counter = reload_in;
          n.st = imste_pkg::RS_HIGH;
        end
      end
      imste_pkg::RS_HIGH:
      begin
        if (!scl_hi)
        begin
          n = f_abort(n);
        end
        else if (expire)
        begin
          n.sda_lo = 1'b1;
          n.sdet = 1'b1;
          n.bit_rate_counter = reload_in;
          n.st = imste_pkg::RS_SDALO;
        end
      end
      imste_pkg::RS_SDALO:
      begin
        if (expire)
        begin
          n.rsreq = 1'b0;
          n.pif = 1'b1;
          n.st = imste_pkg::IDLE;
        end
      end
      imste_pkg::TX_LOW:
      begin
        if (expire)
        begin
          n.scl_lo = 1'b0;
          n.st = imste_pkg::TX_REL;
        end
      end
      imste_pkg::TX_REL:
      begin
        if (scl_hi)
        begin
          n.bit_rate_counter = reload_in;
          n.st = imste_pkg::TX_HIGH;
        end
      end
      imste_pkg::TX_HIGH:
      begin
        if (expire)
        begin
          n.scl_lo = 1'b1;
          n.bit_rate_counter = reload_in;
          if (r.bitn == `IMSTE_ACK_BIT_NUM)
          begin
            n.ack = sda_hi;
            n.pif = 1'b1;
            n.sda_lo = 1'b0;
            n.st = imste_pkg::IDLE;
          end
          else
          begin
            n.bitn = r.bitn + 4'h1;
            n.shift = {r.shift[6:0], 1'b0};
            n.st = imste_pkg::TX_LOW;
            if (r.bitn == `IMSTE_LAST_DATA_BIT)
            begin
              n.bf = 1'b0;
              n.sda_lo = 1'b0;
            end
            else
            begin
              n.sda_lo = ~r.shift[6];
            end
          end
        end
      end
      default:
      begin
        n.st = imste_pkg::IDLE;
      end
    endcase
    busy_nxt = (n.st != imste_pkg::IDLE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '{st: imste_pkg::IDLE, bit_rate_counter: `IMSTE_BRG_RST, div: 4'h0, age: 4'hF,
             bitn: 4'h0, shift: `IMSTE_BYTE_RST, txbuf: `IMSTE_BYTE_RST,
             scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1, default: 1'b0};
      busy_r <= 1'b0;
    end
    else
    begin
      r <= n;
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================
  // outputs: open drain, only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = r.scl_lo;
  assign sda_oe_out = r.sda_lo;
  assign start_request_out = r.sreq;
  assign repeated_start_request_out = r.rsreq;
  assign start_det_out = r.sdet;
  assign buffer_full_flag_out = r.bf;
  assign ack_status_bit_out = r.ack;
  assign write_collision_flag_out = r.write_collision_flag;
  assign bus_collision_flag_out = r.bcl;
  assign port_interrupt_flag_out = r.pif;
  assign transmit_buffer_out = r.txbuf;
  assign busy_out = busy_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_stretch_hold: assert property ((r.st == imste_pkg::TX_REL && !r.scl_s) |=> r.st == imste_pkg::TX_REL)
    else $error("counter ran while clock held low");
  a_reload_on_high: assert property ((r.st == imste_pkg::TX_REL && r.scl_s) |=> r.bit_rate_counter == $past(reload_in))
    else $error("no reload on clock high");
  a_start_begin: assert property ((r.st == imste_pkg::IDLE && r.sreq && r.scl_s && r.sda_s)
    |=> r.st == imste_pkg::S_WAIT && r.bit_rate_counter == $past(reload_in))
    else $error("start did not begin counting");
  a_start_edge: assert property ((r.st == imste_pkg::S_WAIT && r.bit_rate_counter == 7'h00 && r.scl_s && r.sda_s)
    |=> r.sda_lo && r.sdet && !r.scl_lo)
    else $error("start edge missing");
  a_start_done: assert property ((r.st == imste_pkg::S_HOLD && r.bit_rate_counter == 7'h00)
    |=> !r.sreq && r.sda_lo && r.st == imste_pkg::IDLE)
    else $error("start did not complete");
  a_start_coll: assert property ((r.st == imste_pkg::S_WAIT && !r.scl_s)
    |=> r.bcl && r.st == imste_pkg::IDLE && !r.sda_lo && !r.sreq)
    else $error("start collision not handled");
  a_write_collision_flag_start: assert property ((tx_wr_in && start_busy) |=> r.write_collision_flag && $stable(r.txbuf))
    else $error("buffer write during start");
  a_ctrl_locked: assert property ((ctrl2_wr_in && start_busy && !(r.st == imste_pkg::S_HOLD && r.bit_rate_counter == 7'h00)
    && !(r.st == imste_pkg::RS_SDALO && r.bit_rate_counter == 7'h00)) |=> $stable(r.sreq))
    else $error("request write not ignored");
  a_rs_idle_only: assert property ((ctrl2_wr_in && r.st != imste_pkg::IDLE && !r.rsreq) |=> !r.rsreq)
    else $error("repeated start taken while busy");
  a_rs_coll: assert property ((r.st == imste_pkg::RS_HIGH && !r.scl_s) |=> r.bcl && !r.scl_lo && !r.sda_lo)
    else $error("repeated start collision missed");
  a_bf_set: assert property ((r.st == imste_pkg::IDLE && tx_wr_in && !r.sreq && !r.rsreq)
    |=> r.bf && r.scl_lo ##1 r.st == imste_pkg::TX_LOW)
    else $error("buffer full not set");
  a_ack_release: assert property ((r.st == imste_pkg::TX_HIGH && r.bit_rate_counter == 7'h00 && r.bitn == 4'h7)
    |=> !r.bf && !r.sda_lo && r.scl_lo)
    else $error("data not released for ack");
  a_ack_sample: assert property ((r.st == imste_pkg::TX_HIGH && r.bit_rate_counter == 7'h00 && r.bitn == 4'h8)
    |=> r.ack == $past(r.sda_s) && r.pif && r.scl_lo && !r.sda_lo)
    else $error("ack not sampled");
  a_write_collision_flag_sticky: assert property ((r.write_collision_flag && !write_collision_flag_clr_in) |=> r.write_collision_flag)
    else $error("write collision cleared by hardware");

endmodule
`default_nettype wire

// ===== tb/imste_slave_model.sv
// two-wire slave model: pull-ups, clock stretching, acknowledge, forced lows
`timescale 1ns/1ps
`default_nettype none
module imste_slave_model (
  // clock
  input wire logic clk_in,
  // master pull-downs
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  // behaviour controls
  input wire logic ack_en_in,
  input wire logic [3:0] stretch_in,
  input wire logic hold_scl_in,
  input wire logic hold_sda_in,
  // wire levels
  output logic scl_out,
  output logic sda_out
);
  logic ack_drive = 1'b0;
  logic str_drive = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int nbit = 0;
  int str_cnt = 0;
  // ==========================================================
  // wired-and with pull-ups, no party ever drives high
  assign scl_out = !(scl_oe_in || str_drive || hold_scl_in);
  assign sda_out = !(sda_oe_in || ack_drive || hold_sda_in);
  // ==========================================================
  // bit counting, ack after the eighth falling edge, stretch after each fall
  always @(posedge clk_in)
  begin
    scl_q <= scl_out;
    sda_q <= sda_out;
    if (scl_q && scl_out && sda_q && !sda_out)
      nbit <= 0;
    if (scl_q && !scl_out)
    begin
      nbit <= nbit + 1;
      ack_drive <= (nbit == 8) && ack_en_in;
      str_drive <= (stretch_in != 4'h0);
      str_cnt <= int'(stretch_in);
    end
    else if (str_cnt > 1)
      str_cnt <= str_cnt - 1;
    else
      str_drive <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the master start and transmit engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  typedef struct packed {logic [7:0] d; logic ack; logic [3:0] str;} imste_row_type;
  logic clk_in = 0, rst_n_in = 0, ctrl2_wr = 0, tx_wr = 0;
  logic write_collision_flag_clr = 0, bcl_clr = 0, pif_clr = 0, sdet_clr = 0;
  logic [4:0] ctrl2_d = 5'h00;
  logic [7:0] tx_d = 8'h00, got = 8'h00, tbuf;
  logic [6:0] reload = 7'h03;
  logic ack_en = 1, hold_scl = 0, hold_sda = 0, scl_q = 1, sda_q = 1, saw_start = 0, mid = 0;
  logic [3:0] stretch = 4'h0;
  logic scl_w, sda_w, scl_oe, sda_oe, sreq, rsreq, sdet, bf, ackst, write_collision_flag, bcl, pif, busy;
  int n_mismatch = 0, checks_done = 0, hi = 0, hi_min = 999, hi_max = 0, nrise = 0;
  imste_row_type rows [4] = '{'{8'hA5, 1'b1, 4'h0}, '{8'h3C, 1'b0, 4'hF},
                            '{8'hFF, 1'b1, 4'hC}, '{8'h01, 1'b0, 4'h0}};
  imste_engine imste_engine_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .reload_in(reload),
    .ctrl2_wr_in(ctrl2_wr), .ctrl2_data_in(ctrl2_d), .tx_wr_in(tx_wr), .tx_data_in(tx_d),
    .write_collision_flag_clr_in(write_collision_flag_clr), .bcl_clr_in(bcl_clr), .pif_clr_in(pif_clr), .sdet_clr_in(sdet_clr),
    .start_request_out(sreq), .repeated_start_request_out(rsreq), .start_det_out(sdet),
    .buffer_full_flag_out(bf), .ack_status_bit_out(ackst), .write_collision_flag_out(write_collision_flag),
    .bus_collision_flag_out(bcl), .port_interrupt_flag_out(pif), .transmit_buffer_out(tbuf),
    .busy_out(busy));
  imste_slave_model imste_slave_model_inst (.clk_in(clk_in), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
    .ack_en_in(ack_en), .stretch_in(stretch), .hold_scl_in(hold_scl), .hold_sda_in(hold_sda),
    .scl_out(scl_w), .sda_out(sda_w));
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // ==========================================================
  // wire monitor: start conditions, bits at rising clock, high-phase lengths
  always @(posedge clk_in)
  begin
    scl_q <= scl_w;
    sda_q <= sda_w;
    if (scl_q && scl_w && sda_q && !sda_w)
      saw_start <= 1'b1;
    if (!scl_q && scl_w)
    begin
      nrise <= nrise + 1;
      if (nrise < 8)
        got <= {got[6:0], sda_w};
    end
    hi <= scl_w ? hi + 1 : 0;
    if (scl_q && !scl_w && nrise > 0)
    begin
      hi_min <= (hi < hi_min) ? hi : hi_min;
      hi_max <= (hi > hi_max) ? hi : hi_max;
    end
  end
  // ==========================================================
  // tasks
  task automatic tick();
    @(negedge clk_in);
  endtask
  task automatic conclude();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ctrl_write(input logic [4:0] d);
    ctrl2_d = d;
    ctrl2_wr = 1;
    tick();
    ctrl2_wr = 0;
    tick();
  endtask
  task automatic tx_write(input logic [7:0] d);
    tx_d = d;
    tx_wr = 1;
    tick();
    tx_wr = 0;
  endtask
  task automatic clr_all();
    {write_collision_flag_clr, bcl_clr, pif_clr, sdet_clr} = 4'hF;
    tick();
    {write_collision_flag_clr, bcl_clr, pif_clr, sdet_clr} = 4'h0;
    tick();
  endtask
  // bounded wait for completion (pif with no request pending) or collision
  task automatic wait_flag(input bit coll);
    int n;
    mid = 0;
    for (n = 0; n < 3000; n++)
    begin
      if (sdet === 1'b1 && pif === 1'b0)
        mid = 1;
      if (coll ? (bcl === 1'b1) : (pif === 1'b1 && sreq === 1'b0 && rsreq === 1'b0))
        break;
      tick();
    end
    if (n == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic start_seq(input logic [4:0] code);
    saw_start = 0;
    ctrl_write(code);
    wait_flag(0);
    `CHK(saw_start, 1'b1)
    `CHK(sdet, 1'b1)
    `CHK({sreq, rsreq}, 2'b00)
    `CHK({scl_oe, sda_oe}, 2'b01)
    if (code == 5'h02)
      `CHK(mid, 1'b1)
    clr_all();
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) tick();
    rst_n_in = 1;
    `CHK({busy, scl_oe, sda_oe, bf, write_collision_flag, tbuf}, 13'h0000)
    repeat (4) tick();
    for (int i = 0; i < 4; i++)
    begin
      start_seq(i == 0 ? 5'h01 : 5'h02);
      ack_en = rows[i].ack;
      stretch = rows[i].str;
      nrise = 0;
      hi_min = 999;
      hi_max = 0;
      tx_write(rows[i].d);
      `CHK({busy, bf, scl_oe, sda_oe}, {3'b111, ~rows[i].d[7]})
      if (i == 1)
      begin
        repeat (20) tick();
        tx_write(8'hEE);
        `CHK({write_collision_flag, tbuf}, {1'b1, rows[i].d})
        ctrl_write(5'h02);
        `CHK(rsreq, 1'b0)
      end
      wait_flag(0);
      `CHK(got, rows[i].d)
      `CHK(ackst, ~rows[i].ack)
      `CHK({busy, bf, scl_oe, sda_oe}, 4'b0010)
      `CHK(nrise, 9)
      `CHK(hi_min >= 2 * reload + 1, 1'b1)
      `CHK(hi_max <= 2 * reload + 8, 1'b1)
      `CHK(write_collision_flag, i == 1)
      clr_all();
      `CHK(write_collision_flag, 1'b0)
    end
    // early rewrite lands in the buffer but still flags
    start_seq(5'h02);
    tx_write(8'hA5);
    tick();
    tx_write(8'h5A);
    `CHK({write_collision_flag, tbuf}, 9'h15A)
    wait_flag(0);
    clr_all();
    // writes during a repeated start
    ctrl_write(5'h02);
    tick();
    tx_write(8'h77);
    `CHK({write_collision_flag, tbuf}, 9'h15A)
    ctrl_write(5'h00);
    `CHK(rsreq, 1'b1)
    wait_flag(0);
    clr_all();
    // repeated start with data held low by another party
    hold_sda = 1;
    ctrl_write(5'h02);
    wait_flag(1);
    `CHK({rsreq, scl_oe, sda_oe}, 3'b000)
    hold_sda = 0;
    clr_all();
    // start on a bus with both lines low
    {hold_scl, hold_sda} = 2'b11;
    repeat (3) tick();
    ctrl_write(5'h01);
    wait_flag(1);
    `CHK({sreq, sda_oe}, 2'b00)
    {hold_scl, hold_sda} = 2'b00;
    clr_all();
    repeat (4) tick();
    // clock pulled low before the start drives data
    ctrl_write(5'h01);
    // pull early enough that the synchronised low lands well before expiry
    tick();
    hold_scl = 1;
    wait_flag(1);
    `CHK({sreq, sda_oe, scl_oe}, 3'b000)
    hold_scl = 0;
    clr_all();
    repeat (4) tick();
    // buffer and control writes during a plain start
    ctrl_write(5'h01);
    tick();
    tx_write(8'h11);
    `CHK({write_collision_flag, tbuf}, 9'h15A)
    ctrl_write(5'h00);
    `CHK(sreq, 1'b1)
    wait_flag(0);
    `CHK({sreq, sda_oe, write_collision_flag}, 3'b011)
    conclude();
  end
endmodule
`default_nettype wire
